// ---- tb/wasu_core_test.sv ----
`timescale 1ns/1ns
`default_nettype none

module wasu_core_test import wasu_pkg::*;;

	// ----------------------------------------------------------------
	// clock, reset, design and sequencer
	// ----------------------------------------------------------------
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic ce = 1'b1;
	logic req_valid, ready, done, reject;
	wasu_req_type req;
	wasu_res_type res;
	wasu_flags_type flags, ef;
	int fails = 0;
	int n_checks = 0;
	int cyc = 0;

	always #4 mclk = ~mclk;

	wasu_core dut (.i_mclk(mclk), .i_reset_n(reset_n), .i_ce(ce),
		.i_req_valid(req_valid), .i_req(req), .o_ready(ready),
		.o_done(done), .o_reject(reject), .o_res(res), .o_flags(flags));

	wasu_seq_model seq (.i_mclk(mclk), .i_ready(ready), .i_done(done),
		.i_reject(reject), .o_valid(req_valid), .o_req(req));

	// ----------------------------------------------------------------
	// reporting
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		if (fails == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// hang guard, far above the few thousand cycles the run needs
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			complete_run();
		end
	end

	// ----------------------------------------------------------------
	// expectations
	// ----------------------------------------------------------------
	function automatic int lat_of(wasu_req_type r);
		int l;
		logic w, id;
		w = r.op inside {OP_WADD, OP_WSUB, OP_WCMP};
		id = r.op inside {OP_BINC, OP_BDEC, OP_WINC, OP_WDEC};
		l = 1;
		if (w && r.loc == LOC_MEM) l = r.code_flash ? 4 : 1;
		if (w && r.loc == LOC_MEM_ES) l = r.code_flash ? 5 : 2;
		if (id && r.loc != LOC_NONE) l = (r.loc == LOC_MEM_ES) ? 3 : 2;
		return r.ram_fetch ? 2 * l + 3 : l;
	endfunction

	// single steps, as a shift is described, not a barrel formula
	function automatic void calc(input wasu_req_type r,
		inout wasu_flags_type f, output logic [15:0] v, output logic [1:0] wr);
		logic [16:0] s;
		logic [7:0] b;
		logic byt, t, add;
		b = r.opnd[7:0];
		add = (r.op == OP_WADD || r.op == OP_BINC || r.op == OP_WINC);
		byt = r.op inside {OP_BSHR, OP_BSHL, OP_BSAR};
		wr = {1'b0, r.loc != LOC_NONE};
		v = add ? r.opnd + 16'h0001 : r.opnd - 16'h0001;
		case (r.op)
		OP_WADD, OP_WSUB, OP_WCMP: begin
			s = add ? {1'b0, r.acc} + r.opnd : {1'b0, r.acc} - r.opnd;
			f.cy = s[16];
			f.ac = add ? (r.acc[3:0] + r.opnd[3:0] > 15) : (r.acc[3:0] < r.opnd[3:0]);
			f.z = (s[15:0] == 16'h0000);
			v = s[15:0];
			wr = {r.op != OP_WCMP, 1'b0};
		end
		OP_MUL: begin
			v = r.acc[15:8] * r.acc[7:0];
			wr = 2'b10;
		end
		OP_BINC, OP_BDEC: begin
			v = {8'h00, add ? b + 8'h01 : b - 8'h01};
			f.z = (v[7:0] == 8'h00);
			f.ac = add ? (b[3:0] == 4'hF) : (b[3:0] == 4'h0);
		end
		OP_WINC, OP_WDEC: ;
		default: begin
			v = byt ? {8'h00, b} : r.opnd;
			for (int i = 0; i < int'(r.cnt); i++) begin
				if (r.op inside {OP_BSHL, OP_WSHL}) begin
					f.cy = byt ? v[7] : v[15];
					v = byt ? {8'h00, v[6:0], 1'b0} : {v[14:0], 1'b0};
				end else begin
					f.cy = v[0];
					t = (r.op inside {OP_BSAR, OP_WSAR}) & (byt ? v[7] : v[15]);
					v = byt ? {8'h00, t, v[7:1]} : {t, v[15:1]};
				end
			end
		end
		endcase
	endfunction

	// ----------------------------------------------------------------
	// stimulus helpers
	// ----------------------------------------------------------------
	function automatic wasu_req_type mk(wasu_op_type op, wasu_loc_type loc,
		logic [15:0] a, logic [15:0] o, logic [3:0] c);
		wasu_req_type r;
		r = '0;
		r.op = op;
		r.loc = loc;
		r.acc = a;
		r.opnd = o;
		r.cnt = c;
		return r;
	endfunction

	function automatic wasu_req_type rnd_req();
		wasu_req_type r;
		logic byt;
		r = mk(wasu_op_type'($urandom_range(0, 13)),
			wasu_loc_type'($urandom_range(0, 3)), 16'($urandom),
			16'($urandom), 4'h0);
		byt = r.op inside {OP_BSHR, OP_BSHL, OP_BSAR};
		r.code_flash = 1'($urandom);
		r.ram_fetch = 1'($urandom);
		if (r.op == OP_MUL || r.op >= OP_BSHR) r.loc = LOC_NONE;
		r.cnt = 4'($urandom_range(1, byt ? 7 : 15));
		r.opnd_is_acc = (r.op inside {OP_WADD, OP_WCMP}) && !r.loc[1] && !r.loc[0];
		if (r.opnd_is_acc) r.opnd = r.acc;
		return r;
	endfunction

	// one request through the sequencer, every answer compared
	task automatic run(input wasu_req_type r, input logic bad);
		int k, lows, l;
		logic rj;
		logic [15:0] v, m;
		logic [1:0] wr;
		wasu_flags_type f0;
		f0 = ef;
		l = bad ? 1 : lat_of(r);
		if (!bad) calc(r, ef, v, wr);
		seq.issue(r, k, rj, lows);
		check({rj, done}, {bad, !bad});
		check(k, l);
		check(lows, l - 1);
		check(flags, bad ? f0 : ef);
		if (!bad) begin
			m = (r.op == OP_WCMP) ? 16'h0000 : 16'hFFFF;
			if (r.op inside {OP_BSHR, OP_BSHL, OP_BSAR}) m = 16'h00FF;
			check(res.result & m, v & m);
			if (r.op < OP_BSHR) check({res.wr_acc, res.wr_mem}, wr);
			check(res.wr_opnd, r.op > OP_MUL);
		end
	endtask

	task automatic do_reset();
		reset_n = 1'b0;
		repeat (8) @(negedge mclk);
		reset_n = 1'b1;
		ef = '0;
		check({ready, done, reject, flags, res}, {3'b100, 22'h0});
		// first request only in the cycle after the release edge
		@(negedge mclk);
	endtask

	// ----------------------------------------------------------------
	// main sequence: corners back to back, then random traffic
	// ----------------------------------------------------------------
	initial begin
		wasu_req_type good[$];
		wasu_req_type bad[$];
		void'($urandom(97));
		@(negedge mclk);
		do_reset();
		good = '{mk(OP_WADD, LOC_MEM_ES, 16'hFFFF, 16'h0001, 4'h0),
			mk(OP_WSUB, LOC_SADDR, 16'h0000, 16'h0001, 4'h0),
			mk(OP_WCMP, LOC_MEM, 16'h1234, 16'h1234, 4'h0),
			mk(OP_MUL, LOC_NONE, 16'hFFFF, 16'h0000, 4'h0),
			mk(OP_BINC, LOC_NONE, 16'h0000, 16'h00FF, 4'h0),
			mk(OP_BDEC, LOC_MEM_ES, 16'h0000, 16'h0000, 4'h0),
			mk(OP_WINC, LOC_SADDR, 16'h0000, 16'hFFFF, 4'h0),
			mk(OP_WDEC, LOC_NONE, 16'h0000, 16'h0000, 4'h0),
			mk(OP_WSHR, LOC_NONE, 16'h0000, 16'h8001, 4'hF),
			mk(OP_WSHL, LOC_NONE, 16'h0000, 16'h8001, 4'hF),
			mk(OP_WSAR, LOC_NONE, 16'h0000, 16'h8001, 4'hF),
			mk(OP_BSHR, LOC_NONE, 16'h0000, 16'h0081, 4'h7),
			mk(OP_BSHL, LOC_NONE, 16'h0000, 16'h0081, 4'h7),
			mk(OP_BSAR, LOC_NONE, 16'h0000, 16'h0081, 4'h7)};
		good[0].code_flash = 1'b1;
		good[1].ram_fetch = 1'b1;
		bad = '{mk(OP_BSHR, LOC_NONE, 16'h1234, 16'h0081, 4'h8),
			mk(OP_WSAR, LOC_NONE, 16'h1234, 16'h8001, 4'h0),
			mk(wasu_op_type'(4'hE), LOC_NONE, 16'h1234, 16'h0001, 4'h1),
			mk(wasu_op_type'(4'hF), LOC_NONE, 16'h1234, 16'h0001, 4'h1),
			mk(OP_WSUB, LOC_NONE, 16'h1234, 16'h1234, 4'h0),
			mk(OP_MUL, LOC_MEM, 16'h1234, 16'h0001, 4'h0),
			mk(OP_WSHL, LOC_SADDR, 16'h1234, 16'h0001, 4'h3)};
		bad[4].opnd_is_acc = 1'b1;
		foreach (good[i]) run(good[i], 1'b0);
		foreach (bad[i]) run(bad[i], 1'b1);
		for (int i = 0; i < 400; i++) begin
			run(rnd_req(), 1'b0);
			if ($urandom_range(0, 3) == 0) begin
				// a low enable must stretch the done strobe, not drop it
				seq.idle();
				ce = 1'b0;
				@(negedge mclk);
				check(done, 1'b1);
				ce = 1'b1;
			end
		end
		seq.idle();
		do_reset();
		run(good[0], 1'b0);
		complete_run();
	end

endmodule

`default_nettype wire

// ---- tb/wasu_seq_model.sv ----
`timescale 1ns/1ns
`default_nettype none

module wasu_seq_model import wasu_pkg::*; (
	input wire logic i_mclk,
	input wire logic i_ready,
	input wire logic i_done,
	input wire logic i_reject,
	output logic o_valid,
	output wasu_req_type o_req
);

	// ----------------------------------------------------------------
	// sequencer side of the request handshake
	// ----------------------------------------------------------------
	// stale request fields are flipped so they can never pass for data
	initial begin
		o_valid = 1'b0;
		o_req = '1;
	end

	// release the request, called at a falling edge only
	task automatic idle();
		o_valid = 1'b0;
		o_req = ~o_req;
	endtask

	// hold until taken, then count falling edges up to the answer
	task automatic issue(input wasu_req_type r, output int k,
		output logic rej, output int lows);
		int w;
		w = 0;
		k = 0;
		lows = 0;
		o_valid = 1'b1;
		o_req = r;
		// ready is settled between edges, so look at it on the falling one
		while (i_ready !== 1'b1 && w < 40) begin
			w++;
			@(negedge i_mclk);
		end
		@(posedge i_mclk);
		do begin
			@(negedge i_mclk);
			k++;
			// keep valid only when the answer is here, for back to back
			if (i_done !== 1'b1 && i_reject !== 1'b1) begin
				idle();
				lows += (i_ready === 1'b0);
			end
		end while (i_done !== 1'b1 && i_reject !== 1'b1 && k < 40);
		rej = i_reject;
	endtask

endmodule

`default_nettype wire

// ---- verilog/wasu_cfg.svh ----
`ifndef WASU_CFG_SVH
`define WASU_CFG_SVH

// ----------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------
`define WASU_WORD_W 16
`define WASU_BYTE_W 8
`define WASU_CNT_W 4
`define WASU_LAT_W 4

// ----------------------------------------------------------------------
// cycle counts, in cpu clock cycles
// ----------------------------------------------------------------------
`define WASU_LAT_BASE 4'h1
`define WASU_LAT_ES 4'h2
`define WASU_LAT_CODE 4'h4
`define WASU_LAT_CODE_ES 4'h5
`define WASU_LAT_RMW 4'h2
`define WASU_LAT_RMW_ES 4'h3
`define WASU_LAT_RAM_ADD 4'h3

// ----------------------------------------------------------------------
// shift count limits and half-carry position
// ----------------------------------------------------------------------
`define WASU_BYTE_CNT_MAX 4'h7
`define WASU_WORD_CNT_MAX 4'hF
`define WASU_AC_BIT 4

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define WASU_FLAGS_RST 3'h0
`define WASU_WORD_RST 16'h0000

`endif

// ---- verilog/wasu_core.sv ----
// Notes on behaviour
// - word add of operand to accumulator pair; sum, carry, zero, half-carry.
// - word subtract from accumulator pair; borrow in carry; no self form.
// - word compare sets zero, half-carry, carry; no register written.
// - memory word arithmetic 1 cycle or 4 from code; segment 2 or 5.
// - counts are cpu clocks; second count for code flash reads.
// - fetching from RAM lengthens a count to twice plus three.
// - byte multiply of two accumulator bytes into pair, one cycle, flags kept.
// - byte increment sets zero and half-carry, keeps carry; register one cycle.
// - byte decrement sets zero and half-carry, keeps carry.
// - memory increment or decrement takes 2 cycles, segment form 3.
// - word increment or decrement of a pair, one cycle, no flag change.
// - word increment or decrement also works in place on memory.
// - byte logical right shift, bit 0 to carry, zero in.
// - word logical right shift, bit 0 to carry, zero in at 15.
// - byte logical left shift, bit 7 to carry, zero in, one cycle.
// - word logical left shift, bit 15 to carry, zero in, one cycle.
// - byte arithmetic right shift keeps the sign bit, bit 0 to carry.
// - word arithmetic right shift keeps bit 15, bit 0 to carry.
// - shift count is an immediate from the instruction.
`timescale 1ns/1ns
`default_nettype none
`include "wasu_cfg.svh"

module wasu_core import wasu_pkg::*; (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_ce,
	input wire logic i_req_valid,
	input wire wasu_req_type i_req,
	output logic o_ready,
	output logic o_done,
	output logic o_reject,
	output wasu_res_type o_res,
	output wasu_flags_type o_flags
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	wasu_state_type state_ff;
	logic [`WASU_LAT_W-1:0] cnt_ff;
	logic ready_ff;
	logic done_ff;
	logic reject_ff;
	wasu_res_type res_ff;
	wasu_flags_type flags_ff;
	wasu_flags_type hold_flags_ff;
	wasu_req_type req_ff;

	wasu_res_type nxt_res;
	wasu_flags_type nxt_flags;
	logic [`WASU_LAT_W-1:0] lat;
	logic [`WASU_WORD_W:0] sum;
	logic [`WASU_WORD_W:0] dif;
	logic [`WASU_BYTE_W-1:0] inc8;
	logic [`WASU_BYTE_W-1:0] dec8;
	logic [`WASU_BYTE_W-1:0] bsh;
	logic [`WASU_WORD_W-1:0] wsh;
	logic bcy;
	logic wcy;
	logic is_shift;
	logic is_bshift;
	logic is_incdec;
	logic is_warith;
	logic bad;
	logic accept;
	logic go;
	logic finish;
	wasu_shmode_type mode;

	// ------------------------------------------------------------------
	// operation classes and shifters
	// ------------------------------------------------------------------
	assign is_shift = i_req.op inside {OP_BSHR, OP_WSHR, OP_BSHL, OP_WSHL,
		OP_BSAR, OP_WSAR};
	assign is_bshift = i_req.op inside {OP_BSHR, OP_BSHL, OP_BSAR};
	assign is_incdec = i_req.op inside {OP_BINC, OP_BDEC, OP_WINC, OP_WDEC};
	assign is_warith = i_req.op inside {OP_WADD, OP_WSUB, OP_WCMP};

	// shift direction straight from the opcode
	always_comb begin
		case (i_req.op)
			OP_BSHL, OP_WSHL: mode = SH_LL;
			OP_BSAR, OP_WSAR: mode = SH_AR;
			default: mode = SH_LR;
		endcase
	end

	// count comes from the instruction immediate, not from a register
	wasu_shift #(.W(`WASU_BYTE_W)) u_bshift (
		.i_data(i_req.opnd[`WASU_BYTE_W-1:0]),
		.i_cnt(i_req.cnt[2:0]),
		.i_mode(mode),
		.o_data(bsh),
		.o_carry(bcy)
	);

	wasu_shift #(.W(`WASU_WORD_W)) u_wshift (
		.i_data(i_req.opnd),
		.i_cnt(i_req.cnt),
		.i_mode(mode),
		.o_data(wsh),
		.o_carry(wcy)
	);

	// ------------------------------------------------------------------
	// request check
	// ------------------------------------------------------------------
	// zero or oversize counts have no defined effect, so refuse them
	always_comb begin
		bad = 1'b0;
		if (is_shift) begin
			if (i_req.cnt == 4'h0) begin
				bad = 1'b1;
			end else if (is_bshift && i_req.cnt > `WASU_BYTE_CNT_MAX) begin
				bad = 1'b1;
			end
		end
		if ((is_shift || i_req.op == OP_MUL) && i_req.loc != LOC_NONE) begin
			bad = 1'b1;
		end
		if (i_req.op == OP_WSUB && i_req.opnd_is_acc) begin
			bad = 1'b1;
		end
		if (i_req.op > OP_WSAR) begin
			bad = 1'b1;
		end
	end

	assign accept = i_ce && ready_ff && i_req_valid;
	assign go = accept && !bad;
	assign finish = i_ce && state_ff == ST_BUSY && cnt_ff == 4'h1;

	// ------------------------------------------------------------------
	// cycle count
	// ------------------------------------------------------------------
	always_comb begin
		lat = `WASU_LAT_BASE;
		if (is_warith) begin
			case (i_req.loc)
				LOC_MEM: lat = i_req.code_flash ? `WASU_LAT_CODE
					: `WASU_LAT_BASE;
				LOC_MEM_ES: lat = i_req.code_flash ? `WASU_LAT_CODE_ES
					: `WASU_LAT_ES;
				default: lat = `WASU_LAT_BASE;
			endcase
		end else if (is_incdec) begin
			case (i_req.loc)
				LOC_MEM, LOC_SADDR: lat = `WASU_LAT_RMW;
				LOC_MEM_ES: lat = `WASU_LAT_RMW_ES;
				default: lat = `WASU_LAT_BASE;
			endcase
		end
		// worst case for a RAM fetch, so the sequencer never waits short
		if (i_req.ram_fetch) begin
			lat = {lat[`WASU_LAT_W-2:0], 1'b0} + `WASU_LAT_RAM_ADD;
		end
	end

	// ------------------------------------------------------------------
	// datapath
	// ------------------------------------------------------------------
	assign sum = {1'b0, i_req.acc} + {1'b0, i_req.opnd};
	assign dif = {1'b0, i_req.acc} - {1'b0, i_req.opnd};
	assign inc8 = i_req.opnd[`WASU_BYTE_W-1:0] + 8'h01;
	assign dec8 = i_req.opnd[`WASU_BYTE_W-1:0] - 8'h01;

	// result, destination and next flags; flags not named are kept
	always_comb begin
		nxt_res = '0;
		nxt_flags = flags_ff;
		case (i_req.op)
			OP_WADD: begin
				nxt_res.result = sum[`WASU_WORD_W-1:0];
				nxt_res.wr_acc = 1'b1;
				nxt_flags.z = sum[`WASU_WORD_W-1:0] == `WASU_WORD_RST;
				nxt_flags.ac = i_req.acc[`WASU_AC_BIT] ^
					i_req.opnd[`WASU_AC_BIT] ^ sum[`WASU_AC_BIT];
				nxt_flags.cy = sum[`WASU_WORD_W];
			end
			OP_WSUB, OP_WCMP: begin
				nxt_res.result = dif[`WASU_WORD_W-1:0];
				nxt_res.wr_acc = i_req.op == OP_WSUB;
				nxt_flags.z = dif[`WASU_WORD_W-1:0] == `WASU_WORD_RST;
				nxt_flags.ac = i_req.acc[`WASU_AC_BIT] ^
					i_req.opnd[`WASU_AC_BIT] ^ dif[`WASU_AC_BIT];
				nxt_flags.cy = dif[`WASU_WORD_W];
			end
			OP_MUL: begin
				// flags untouched by the product
				nxt_res.result = {8'h00, i_req.acc[15:8]} *
					{8'h00, i_req.acc[7:0]};
				nxt_res.wr_acc = 1'b1;
			end
			OP_BINC, OP_BDEC: begin
				nxt_res.result = {8'h00, i_req.op == OP_BINC ? inc8 : dec8};
				nxt_res.wr_opnd = 1'b1;
				nxt_flags.z = nxt_res.result[`WASU_BYTE_W-1:0] == 8'h00;
				nxt_flags.ac = i_req.opnd[`WASU_AC_BIT] ^
					nxt_res.result[`WASU_AC_BIT];
			end
			OP_WINC: begin
				nxt_res.result = i_req.opnd + 16'h0001;
				nxt_res.wr_opnd = 1'b1;
			end
			OP_WDEC: begin
				nxt_res.result = i_req.opnd - 16'h0001;
				nxt_res.wr_opnd = 1'b1;
			end
			OP_BSHR, OP_BSHL, OP_BSAR: begin
				nxt_res.result = {8'h00, bsh};
				nxt_res.wr_opnd = 1'b1;
				nxt_flags.cy = bcy;
			end
			OP_WSHR, OP_WSHL, OP_WSAR: begin
				nxt_res.result = wsh;
				nxt_res.wr_opnd = 1'b1;
				nxt_flags.cy = wcy;
			end
			default: nxt_res = '0;
		endcase
		// memory homes are written back by the read-modify-write cycle
		nxt_res.wr_mem = nxt_res.wr_opnd && i_req.loc != LOC_NONE;
	end

	// ------------------------------------------------------------------
	// sequencing
	// ------------------------------------------------------------------
	// single-cycle work never leaves idle, so those ops run back to back
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			state_ff <= ST_IDLE;
			cnt_ff <= 4'h0;
			ready_ff <= 1'b1;
		end else if (i_ce) begin
			if (go && lat != 4'h1) begin
				state_ff <= ST_BUSY;
				cnt_ff <= lat - 4'h1;
				ready_ff <= 1'b0;
			end else if (finish) begin
				state_ff <= ST_IDLE;
				cnt_ff <= 4'h0;
				ready_ff <= 1'b1;
			end else if (state_ff == ST_BUSY) begin
				cnt_ff <= cnt_ff - 4'h1;
			end
		end
	end

	// completion and refusal strobes
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			done_ff <= 1'b0;
			reject_ff <= 1'b0;
		end else if (i_ce) begin
			done_ff <= (go && lat == 4'h1) || finish;
			reject_ff <= accept && bad;
		end
	end

	// result held from acceptance; qualified by the done strobe
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			res_ff <= '0;
			hold_flags_ff <= `WASU_FLAGS_RST;
			req_ff <= '0;
		end else if (i_ce && go) begin
			res_ff <= nxt_res;
			hold_flags_ff <= nxt_flags;
			req_ff <= i_req;
		end
	end

	// flags change only at completion, never while a request waits
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			flags_ff <= `WASU_FLAGS_RST;
		end else if (i_ce) begin
			if (go && lat == 4'h1) begin
				flags_ff <= nxt_flags;
			end else if (finish) begin
				flags_ff <= hold_flags_ff;
			end
		end
	end

	assign o_ready = ready_ff;
	assign o_done = done_ff;
	assign o_reject = reject_ff;
	assign o_res = res_ff;
	assign o_flags = flags_ff;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	property p_wadd;
		@(posedge i_mclk) disable iff (!i_reset_n || !i_ce)
		done_ff && req_ff.op == OP_WADD |-> o_res.wr_acc &&
			{o_flags.cy, o_res.result} == {1'b0, req_ff.acc} +
			{1'b0, req_ff.opnd};
	endproperty
	a_wadd: assert property (p_wadd)
		else $error("word add sum or carry wrong");

	property p_wsub;
		@(posedge i_mclk) disable iff (!i_reset_n || !i_ce)
		done_ff && req_ff.op == OP_WSUB |-> o_res.wr_acc &&
			{o_flags.cy, o_res.result} == {1'b0, req_ff.acc} -
			{1'b0, req_ff.opnd} && o_flags.z == (o_res.result == 16'h0000);
	endproperty
	a_wsub: assert property (p_wsub)
		else $error("word subtract difference or borrow wrong");

	property p_wcmp;
		@(posedge i_mclk) disable iff (!i_reset_n || !i_ce)
		done_ff && req_ff.op == OP_WCMP |-> !o_res.wr_acc &&
			!o_res.wr_opnd && o_flags.cy == (req_ff.acc < req_ff.opnd);
	endproperty
	a_wcmp: assert property (p_wcmp)
		else $error("word compare wrote a register or bad carry");

	property p_lat_es_code;
		@(posedge i_mclk) disable iff (!i_reset_n || !i_ce)
		go && is_warith && i_req.loc == LOC_MEM_ES && i_req.code_flash &&
			!i_req.ram_fetch |-> ##1 !o_done [*4] ##1 o_done;
	endproperty
	a_lat_es_code: assert property (p_lat_es_code)
		else $error("segment code-flash word op not 5 cycles");

	property p_lat_base;
		@(posedge i_mclk) disable iff (!i_reset_n || !i_ce)
		go && i_req.loc == LOC_NONE && !i_req.ram_fetch |-> ##1 o_done;
	endproperty
	a_lat_base: assert property (p_lat_base)
		else $error("register operation not one cycle");

	property p_ram_fetch;
		@(posedge i_mclk) disable iff (!i_reset_n || !i_ce)
		go && i_req.loc == LOC_NONE && i_req.ram_fetch |->
			##1 !o_done [*4] ##1 o_done;
	endproperty
	a_ram_fetch: assert property (p_ram_fetch)
		else $error("ram fetch count not twice plus three");

	property p_mul;
		@(posedge i_mclk) disable iff (!i_reset_n || !i_ce)
		done_ff && req_ff.op == OP_MUL |-> o_flags == $past(o_flags) &&
			o_res.result == req_ff.acc[15:8] * req_ff.acc[7:0];
	endproperty
	a_mul: assert property (p_mul)
		else $error("multiply product wrong or flags moved");

	property p_byte_incdec;
		@(posedge i_mclk) disable iff (!i_reset_n || !i_ce)
		done_ff && req_ff.op inside {OP_BINC, OP_BDEC} |->
			o_flags.cy == $past(o_flags.cy) &&
			o_flags.z == (o_res.result[7:0] == 8'h00);
	endproperty
	a_byte_incdec: assert property (p_byte_incdec)
		else $error("byte step changed carry or zero wrong");

	property p_rmw;
		@(posedge i_mclk) disable iff (!i_reset_n || !i_ce)
		go && is_incdec && i_req.loc == LOC_MEM && !i_req.ram_fetch |->
			##1 !o_done ##1 o_done && o_res.wr_mem;
	endproperty
	a_rmw: assert property (p_rmw)
		else $error("memory step not a two cycle write back");

	property p_word_incdec;
		@(posedge i_mclk) disable iff (!i_reset_n || !i_ce)
		done_ff && req_ff.op inside {OP_WINC, OP_WDEC} |->
			o_flags == $past(o_flags) && o_res.result == (req_ff.op ==
			OP_WINC ? req_ff.opnd + 16'h0001 : req_ff.opnd - 16'h0001);
	endproperty
	a_word_incdec: assert property (p_word_incdec)
		else $error("word step value wrong or flags moved");

	property p_wshift_right;
		@(posedge i_mclk) disable iff (!i_reset_n || !i_ce)
		done_ff && req_ff.op inside {OP_WSHR, OP_WSAR} |->
			o_flags.cy == req_ff.opnd[req_ff.cnt - 4'h1] &&
			o_res.result[15] == (req_ff.op == OP_WSAR && req_ff.opnd[15]) &&
			o_flags.z == $past(o_flags.z);
	endproperty
	a_wshift_right: assert property (p_wshift_right)
		else $error("word right shift carry or top bit wrong");

	property p_bshift;
		@(posedge i_mclk) disable iff (!i_reset_n || !i_ce)
		done_ff && req_ff.op == OP_BSHL |-> o_res.result[7:0] ==
			8'(req_ff.opnd[7:0] << req_ff.cnt) && o_flags.cy ==
			req_ff.opnd[4'h8 - req_ff.cnt];
	endproperty
	a_bshift: assert property (p_bshift)
		else $error("byte left shift value or carry wrong");

	property p_count;
		@(posedge i_mclk) disable iff (!i_reset_n || !i_ce)
		accept && is_bshift && i_req.cnt > 4'h7 |-> ##1 o_reject && !o_done;
	endproperty
	a_count: assert property (p_count)
		else $error("oversize byte shift count not refused");

endmodule
`default_nettype wire

// ---- verilog/wasu_pkg.sv ----
`include "wasu_cfg.svh"

package wasu_pkg;

	// ------------------------------------------------------------------
	// operations, operand homes, shift modes, states
	// ------------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_WADD = 4'h0, OP_WSUB = 4'h1, OP_WCMP = 4'h2, OP_MUL = 4'h3,
		OP_BINC = 4'h4, OP_BDEC = 4'h5, OP_WINC = 4'h6, OP_WDEC = 4'h7,
		OP_BSHR = 4'h8, OP_WSHR = 4'h9, OP_BSHL = 4'hA, OP_WSHL = 4'hB,
		OP_BSAR = 4'hC, OP_WSAR = 4'hD
	} wasu_op_type;

	typedef enum logic [1:0] {
		LOC_NONE = 2'h0, LOC_SADDR = 2'h1, LOC_MEM = 2'h2, LOC_MEM_ES = 2'h3
	} wasu_loc_type;

	typedef enum logic [1:0] {
		SH_LR = 2'h0, SH_LL = 2'h1, SH_AR = 2'h2
	} wasu_shmode_type;

	typedef enum logic {
		ST_IDLE = 1'b0, ST_BUSY = 1'b1
	} wasu_state_type;

	// ------------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		wasu_op_type op;
		wasu_loc_type loc;
		logic code_flash;
		logic ram_fetch;
		logic opnd_is_acc;
		logic [`WASU_WORD_W-1:0] acc;
		logic [`WASU_WORD_W-1:0] opnd;
		logic [`WASU_CNT_W-1:0] cnt;
	} wasu_req_type;

	typedef struct packed {
		logic [`WASU_WORD_W-1:0] result;
		logic wr_acc;
		logic wr_opnd;
		logic wr_mem;
	} wasu_res_type;

	typedef struct packed {
		logic z;
		logic ac;
		logic cy;
	} wasu_flags_type;

endpackage

// ---- verilog/wasu_shift.sv ----
`timescale 1ns/1ns
`default_nettype none

module wasu_shift import wasu_pkg::*; #(
	parameter int W = 8,
	parameter int CW = $clog2(W)
) (
	input wire logic [W-1:0] i_data,
	input wire logic [CW-1:0] i_cnt,
	input wire wasu_shmode_type i_mode,
	output logic [W-1:0] o_data,
	output logic o_carry
);

	// ------------------------------------------------------------------
	// elaboration check
	// ------------------------------------------------------------------
	if (W < 4 || (1 << CW) != W) begin : g_bad_width
		$error("wasu_shift: width must be a power of two, at least 4");
	end

	// ------------------------------------------------------------------
	// step-by-step shifter
	// ------------------------------------------------------------------
	logic [W-1:0] res;
	logic cy;

	// unrolled one bit per step so the carry is the last bit shifted out
	always_comb begin
		res = i_data;
		cy = 1'b0;
		for (int i = 1; i < W; i++) begin
			if (i <= int'(i_cnt)) begin
				case (i_mode)
					SH_LL: begin
						cy = res[W-1];
						res = {res[W-2:0], 1'b0};
					end
					SH_AR: begin
						cy = res[0];
						res = {res[W-1], res[W-1:1]}; // sign stays put
					end
					default: begin
						cy = res[0];
						res = {1'b0, res[W-1:1]};
					end
				endcase
			end
		end
	end

	assign o_data = res;
	assign o_carry = cy;

endmodule
`default_nettype wire
